// *** tcf_pkg.sv ***
/*
 * Shared constants for the timer common-function control block:
 * register indices, field positions, reset values, codes and filter lengths.
 * Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
 */
package tcf_pkg;

    // Register indices; byte address is index times four
    localparam logic [5:0] REG_TIMER_SELECT_IDX = 6'h00; // Per-timer output enables
    localparam logic [5:0] REG_CTRL_IDX         = 6'h01; // timer_common_control
    localparam logic [5:0] REG_PORT3_MODE_IDX   = 6'h02; // Analog enable
    localparam logic [5:0] REG_IRQ_EDGE_IDX     = 6'h03; // Pin interrupt edge select
    localparam logic [5:0] REG_INT_STATUS_IDX   = 6'h04; // Sticky events, write one to clear
    localparam logic [5:0] REG_INT_MASK_IDX     = 6'h05; // Interrupt enables

    // Control register fields
    localparam int         CTRL_MODE_BIT  = 7;
    localparam int         CTRL_SEL_BIT   = 6;
    localparam int         CTRL_FN_LO     = 4;
    localparam int         CTRL_SUB_LO    = 2;
    localparam int         CTRL_FLAG_BIT  = 1;
    localparam logic [7:0] CTRL_RESET     = 8'h00;

    // Other field positions
    localparam int         TSEL_EIGHT_BIT   = 0;
    localparam int         TSEL_SIXTEEN_BIT = 1;
    localparam int         P3M_ANALOG_BIT   = 1;
    localparam int         IRQ_EDGE_LO      = 6;
    localparam int         ST_INTERRUPT_ZERO          = 0;
    localparam int         ST_INTERRUPT_ONE          = 1;
    localparam int         ST_INTERRUPT_TWO          = 2;
    localparam int         ST_DEMOD         = 3;
    localparam int         ST_WIDTH         = 4;

    // Transmit logic combination codes
    localparam logic [1:0] LOGIC_AND  = 2'h0;
    localparam logic [1:0] LOGIC_OR   = 2'h1;
    localparam logic [1:0] LOGIC_NOR  = 2'h2;
    localparam logic [1:0] LOGIC_NAND = 2'h3;

    // Demodulation edge codes, also used for pin interrupt edges
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // Transmit submodes
    localparam logic [1:0] SUB_NORMAL   = 2'h0;
    localparam logic [1:0] SUB_PINGPONG = 2'h1;
    localparam logic [1:0] SUB_FORCE0   = 2'h2;
    localparam logic [1:0] SUB_FORCE1   = 2'h3;

    // Glitch filter codes and lengths in system clock cycles
    localparam logic [1:0] FILT_NONE  = 2'h0;
    localparam logic [1:0] FILT_SHORT = 2'h1;
    localparam logic [1:0] FILT_LONG  = 2'h2;
    localparam logic [3:0] FILTER_SHORT_CYCLES = 4'h4;
    localparam logic [3:0] FILTER_LONG_CYCLES  = 4'h8;

endpackage : tcf_pkg

// *** tcf_edge_if.sv ***
/*
 * Carrier between the control top, the glitch filter and the edge detector.
 * Assumes all three share one clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none

interface tcf_edge_if;
    logic sample;   // Selected raw demodulator input
    logic filtered; // Input after the glitch filter
    logic rise;     // One-cycle pulse on a filtered rising edge
    logic fall;     // One-cycle pulse on a filtered falling edge

    modport filt (input sample, output filtered);
    modport det  (input filtered, output rise, output fall);
    modport ctl  (output sample, input rise, input fall);
endinterface : tcf_edge_if

`default_nettype wire

// *** tcf_glitch_filter.sv ***
/*
 * Glitch filter: a new input level is accepted only after it has held
 * for the selected number of clock cycles, or at once with no filter.
 * Assumes the sample is synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module tcf_glitch_filter
    import tcf_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Filter length code
    input wire logic [1:0] filterCode,
    // Sample in, filtered level out
    tcf_edge_if.filt       lnk
);

    logic [3:0] runLen;      // Cycles the differing level has held
    logic [3:0] next_runLen;
    logic       filtered;
    logic       next_filtered;
    logic [3:0] need;        // Required hold time, zero for no filter

    // Reserved code falls back to no filter, like the reset setting
    always_comb begin
        unique case (filterCode)
            FILT_SHORT: need = FILTER_SHORT_CYCLES;
            FILT_LONG:  need = FILTER_LONG_CYCLES;
            default:    need = 4'h0;
        endcase
    end

    // Next level and run length
    always_comb begin
        next_runLen   = 4'h0;
        next_filtered = filtered;
        if (lnk.sample != filtered) begin
            if ((need == 4'h0) || ((runLen + 4'h1) >= need)) begin
                next_filtered = lnk.sample;
            end else begin
                next_runLen = runLen + 4'h1;
            end
        end
    end

    // State registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            runLen   <= 4'h0;
            filtered <= 1'b0;
        end else begin
            runLen   <= next_runLen;
            filtered <= next_filtered;
        end
    end

    assign lnk.filtered = filtered;

    filter_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        ($changed(filtered) && $past(need) != 4'h0) |-> $past(runLen) == $past(need) - 4'h1)
        else $error("filter accepted level too early");

endmodule : tcf_glitch_filter

`default_nettype wire

// *** tcf_edge_detect.sv ***
/*
 * Edge detector on the filtered demodulator input.
 * Assumes filtered is a registered level on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module tcf_edge_detect
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Filtered level in, edge pulses out
    tcf_edge_if.det  lnk
);

    logic prevLevel; // Filtered level one cycle ago

    // Remember the last level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prevLevel <= 1'b0;
        end else begin
            prevLevel <= lnk.filtered;
        end
    end

    // Pulses last exactly one cycle per transition
    assign lnk.rise = lnk.filtered & ~prevLevel;
    assign lnk.fall = ~lnk.filtered & prevLevel;

endmodule : tcf_edge_detect

`default_nettype wire

// *** tcf_timer_common_control.sv ***
/*
 * Timer common-function control: an AHB-Lite slave holding the common
 * control register, transmit output combination and submodes, the
 * demodulator input path, Port 3 output routing, comparator control and
 * pin interrupts with a sticky status register.
 * Assumes timer engines, comparators and pins are synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - bit 7 mode; bit 6 routes combined output
// - demod bit 6 picks analog-in-one or port-two pin
// - transmit bits 5-4: AND, OR, NOR, NAND
// - demod bits 5-4: falling, rising, both edges
// - transmit bits 3-2: normal, alternating, force 0/1
// - demod bits 3-2: no, 4-cycle, 8-cycle filter
// - transmit bit 1 sets initial eight-bit output
// - demod bit 1 rising flag, write one clears
// - Port 3 outputs timers under select bits
// - comparators enabled by Port 3 mode bit
// - analog-in pins interrupt on selected edges
// - pins map to interrupts two, zero, one
// - comparators off in stop mode
module tcf_timer_common_control
    import tcf_pkg::*;
#(
    parameter int ADDR_W = 8 // Bus address width
)
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Timer engines
    input  wire logic              eightBitTimerOutput,
    input  wire logic              sixteenBitTimerOutput,
    output logic                   demodMode,
    output logic                   alternatingTimerMode,
    output logic                   initialEightLevel,
    output logic                   demodEdge,
    // Pins and analog front end
    input  wire logic              analogInOnePin,
    input  wire logic              analogInTwoPin,
    input  wire logic              referenceTwoPin,
    input  wire logic              portTwoBitZeroPin,
    input  wire logic              comparatorOneResult,
    input  wire logic              comparatorTwoResult,
    input  wire logic              stopMode,
    output logic                   comparatorPowerEn,
    // Port 3 outputs and their port data
    input  wire logic [7:4]        portThreeData,
    output logic [7:4]             portThreeOut,
    // Interrupts
    output logic                   interruptZero,
    output logic                   interruptOne,
    output logic                   interruptTwo,
    output logic                   irq
);

    // Bus phase state
    logic       wrPend, next_wrPend;     // Write data phase pending
    logic [5:0] wrIdx, next_wrIdx;       // Register index of that write
    logic [31:0] next_hrdata;
    // Software registers
    logic [7:0] ctrl, next_ctrl;         // Bits 7..2 stored, bit 1 below
    logic       initLevel, next_initLevel;
    logic       riseFlag, next_riseFlag;
    logic [1:0] timerSel, next_timerSel;
    logic       analogEn, next_analogEn;
    logic [1:0] irqEdge, next_irqEdge;
    logic [ST_WIDTH-1:0] status, next_status;
    logic [ST_WIDTH-1:0] mask, next_mask;
    // Pin and output state
    logic [2:0] pinPrev, next_pinPrev;   // Interrupt sources last cycle
    logic [2:0] pinHit;                  // Edges seen this cycle
    logic [7:4] next_portThreeOut;
    logic [2:0] next_intPulse;
    logic       addrTaken, wrCtrl, flagClear;
    logic [2:0] pinSrc;
    logic       compOne, compTwo, sixteenEff, combined;
    logic [1:0] fnCode, subCode;

    tcf_edge_if edgeLnk ();

    // Edge match for an interrupt source against the select code
    function automatic logic edgeMatch(input logic cur, input logic prev,
                                       input logic [1:0] sel);
        unique case (sel)
            EDGE_RISE: edgeMatch = cur & ~prev;
            EDGE_BOTH: edgeMatch = cur ^ prev;
            default:   edgeMatch = ~cur & prev; // Falling, reserved too
        endcase
    endfunction : edgeMatch

    // Register read value for an index; unmapped reads as zero
    function automatic logic [31:0] readReg(input logic [5:0] idx);
        readReg = 32'h0;
        unique case (idx)
            REG_TIMER_SELECT_IDX: readReg[1:0] = timerSel;
            REG_CTRL_IDX: begin
                readReg[7:2] = ctrl[7:2];
                readReg[CTRL_FLAG_BIT] = demodMode ? riseFlag : initLevel;
            end
            REG_PORT3_MODE_IDX: readReg[P3M_ANALOG_BIT] = analogEn;
            REG_IRQ_EDGE_IDX:   readReg[IRQ_EDGE_LO +: 2] = irqEdge;
            REG_INT_STATUS_IDX: readReg[ST_WIDTH-1:0] = status;
            REG_INT_MASK_IDX:   readReg[ST_WIDTH-1:0] = mask;
            default:            readReg = 32'h0;
        endcase
    endfunction : readReg

    // Field views of the control register
    assign demodMode            = ctrl[CTRL_MODE_BIT];
    assign fnCode               = ctrl[CTRL_FN_LO +: 2];
    assign subCode              = ctrl[CTRL_SUB_LO +: 2];
    assign alternatingTimerMode = !demodMode && (subCode == SUB_PINGPONG);
    assign initialEightLevel    = initLevel;

    // Comparators lose power in stop mode; results read low then
    assign comparatorPowerEn = analogEn & ~stopMode;
    assign compOne           = comparatorPowerEn & comparatorOneResult;
    assign compTwo           = comparatorPowerEn & comparatorTwoResult;

    // Interrupt sources: analog-in ones use the comparator in analog mode, else the pin; reference pin direct
    assign pinSrc[ST_INTERRUPT_TWO] = analogEn ? compOne : analogInOnePin;
    assign pinSrc[ST_INTERRUPT_ZERO] = analogEn ? compTwo : analogInTwoPin;
    assign pinSrc[ST_INTERRUPT_ONE] = referenceTwoPin;

    // Demodulator input select
    assign edgeLnk.sample = ctrl[CTRL_SEL_BIT] ? portTwoBitZeroPin : pinSrc[ST_INTERRUPT_TWO];

    tcf_glitch_filter u_filter (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .filterCode (demodMode ? subCode : FILT_NONE),
        .lnk        (edgeLnk)
    );

    tcf_edge_detect u_detect (
        .ref_clk (ref_clk),
        .rst     (rst),
        .lnk     (edgeLnk)
    );

    // Demodulator edge pulse; reserved code acts as falling
    always_comb begin
        unique case (fnCode)
            EDGE_RISE: demodEdge = demodMode & edgeLnk.rise;
            EDGE_BOTH: demodEdge = demodMode & (edgeLnk.rise | edgeLnk.fall);
            default:   demodEdge = demodMode & edgeLnk.fall;
        endcase
    end

    // Transmit output combination; forced submodes override the 16-bit output.
    // In demodulation the same bits pick the filter, so nothing is forced then.
    always_comb begin
        unique case (demodMode ? SUB_NORMAL : subCode)
            SUB_FORCE0: sixteenEff = 1'b0;
            SUB_FORCE1: sixteenEff = 1'b1;
            default:    sixteenEff = sixteenBitTimerOutput;
        endcase
        unique case (fnCode)
            LOGIC_OR:   combined = eightBitTimerOutput | sixteenEff;
            LOGIC_NOR:  combined = ~(eightBitTimerOutput | sixteenEff);
            LOGIC_NAND: combined = ~(eightBitTimerOutput & sixteenEff);
            default:    combined = eightBitTimerOutput & sixteenEff;
        endcase
    end

    // Port 3 routing, registered so the pins never see decode glitches
    always_comb begin
        next_portThreeOut[4] = timerSel[TSEL_EIGHT_BIT] ? eightBitTimerOutput :
                               (analogEn ? compOne : portThreeData[4]);
        next_portThreeOut[5] = timerSel[TSEL_SIXTEEN_BIT] ? sixteenEff :
                               portThreeData[5];
        next_portThreeOut[6] = (!demodMode && ctrl[CTRL_SEL_BIT]) ? combined :
                               portThreeData[6];
        next_portThreeOut[7] = analogEn ? compTwo : portThreeData[7];
    end

    // Pin interrupt edges; both analog-in pins share one edge select
    always_comb begin
        next_pinPrev = pinSrc;
        for (int i = 0; i < 3; i++) begin
            pinHit[i] = edgeMatch(pinSrc[i], pinPrev[i], irqEdge);
        end
        next_intPulse = pinHit;
    end

    // Bus address phase decode; always ready, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addrTaken = hsel & htrans[1] & hready;
    assign wrCtrl    = wrPend && (wrIdx == REG_CTRL_IDX);
    assign flagClear = wrCtrl && hwdata[CTRL_MODE_BIT] && hwdata[CTRL_FLAG_BIT];

    // Next register values; hardware sets win over software clears
    always_comb begin
        next_wrPend    = addrTaken & hwrite;
        next_wrIdx     = haddr[ADDR_W-1:2];
        next_hrdata    = (addrTaken && !hwrite) ? readReg(haddr[ADDR_W-1:2]) : hrdata;
        next_ctrl      = ctrl;
        next_initLevel = initLevel;
        next_timerSel  = timerSel;
        next_analogEn  = analogEn;
        next_irqEdge   = irqEdge;
        next_mask      = mask;
        next_status    = status;
        if (wrPend) begin
            unique case (wrIdx)
                REG_TIMER_SELECT_IDX: next_timerSel = hwdata[1:0];
                REG_CTRL_IDX: begin
                    next_ctrl = {hwdata[7:2], 2'h0};
                    if (!hwdata[CTRL_MODE_BIT]) begin
                        next_initLevel = hwdata[CTRL_FLAG_BIT];
                    end
                end
                REG_PORT3_MODE_IDX: next_analogEn = hwdata[P3M_ANALOG_BIT];
                REG_IRQ_EDGE_IDX:   next_irqEdge  = hwdata[IRQ_EDGE_LO +: 2];
                REG_INT_STATUS_IDX: next_status   = status & ~hwdata[ST_WIDTH-1:0];
                REG_INT_MASK_IDX:   next_mask     = hwdata[ST_WIDTH-1:0];
                default:            next_mask     = mask; // Unmapped write ignored
            endcase
        end
        next_status[ST_INTERRUPT_ZERO]  = next_status[ST_INTERRUPT_ZERO] | pinHit[ST_INTERRUPT_ZERO];
        next_status[ST_INTERRUPT_ONE]  = next_status[ST_INTERRUPT_ONE] | pinHit[ST_INTERRUPT_ONE];
        next_status[ST_INTERRUPT_TWO]  = next_status[ST_INTERRUPT_TWO] | pinHit[ST_INTERRUPT_TWO];
        next_status[ST_DEMOD] = next_status[ST_DEMOD] | demodEdge;
        // Rising flag counts only in demodulation mode
        next_riseFlag = (riseFlag & ~flagClear) | (demodMode & edgeLnk.rise);
    end

    // All state registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrPend        <= 1'b0;
            wrIdx         <= 6'h00;
            hrdata        <= 32'h0;
            ctrl          <= CTRL_RESET;
            initLevel     <= 1'b0;
            riseFlag      <= 1'b0;
            timerSel      <= 2'h0;
            analogEn      <= 1'b0;
            irqEdge       <= 2'h0;
            status        <= '0;
            mask          <= '0;
            pinPrev       <= 3'h0;
            portThreeOut  <= 4'h0;
            interruptZero <= 1'b0;
            interruptOne  <= 1'b0;
            interruptTwo  <= 1'b0;
        end else begin
            wrPend        <= next_wrPend;
            wrIdx         <= next_wrIdx;
            hrdata        <= next_hrdata;
            ctrl          <= next_ctrl;
            initLevel     <= next_initLevel;
            riseFlag      <= next_riseFlag;
            timerSel      <= next_timerSel;
            analogEn      <= next_analogEn;
            irqEdge       <= next_irqEdge;
            status        <= next_status;
            mask          <= next_mask;
            pinPrev       <= next_pinPrev;
            portThreeOut  <= next_portThreeOut;
            interruptZero <= next_intPulse[ST_INTERRUPT_ZERO];
            interruptOne  <= next_intPulse[ST_INTERRUPT_ONE];
            interruptTwo  <= next_intPulse[ST_INTERRUPT_TWO];
        end
    end

    // Level interrupt while any unmasked event is pending
    assign irq = |(status & mask);

    // Checks on the flag, pin routing and interrupts
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence riseSeen;
        demodMode && edgeLnk.rise;
    endsequence

    sequence flagUpHeld;
        riseFlag ##1 riseFlag;
    endsequence

    rise_flag_a: assert property (riseSeen ##1 !flagClear |-> flagUpHeld)
        else $error("rising flag not kept");

    flag_clear_a: assert property (flagClear && !(demodMode && edgeLnk.rise) |=> !riseFlag)
        else $error("rising flag not cleared");

    shared_pin_a: assert property (!demodMode && ctrl[CTRL_SEL_BIT] && fnCode == LOGIC_NOR
        |=> portThreeOut[6] == !($past(eightBitTimerOutput) | $past(sixteenEff)))
        else $error("shared pin not NOR of timers");

    demod_input_a: assert property (demodMode && ctrl[CTRL_SEL_BIT]
        |-> edgeLnk.sample == portTwoBitZeroPin)
        else $error("demod input not port two pin");

    force_low_a: assert property (!demodMode && subCode == SUB_FORCE0
        && timerSel[TSEL_SIXTEEN_BIT] |=> !portThreeOut[5])
        else $error("sixteen-bit output not forced low");

    both_edges_a: assert property (demodMode && fnCode == EDGE_BOTH && edgeLnk.fall
        |-> demodEdge)
        else $error("falling edge missed in both-edge mode");

    init_level_a: assert property (wrCtrl && !hwdata[CTRL_MODE_BIT]
        |=> initialEightLevel == $past(hwdata[CTRL_FLAG_BIT]))
        else $error("initial level not taken");

    stop_power_a: assert property (stopMode |-> !comparatorPowerEn)
        else $error("comparator powered in stop mode");

    pin_irq_a: assert property (irqEdge == EDGE_RISE && $rose(pinSrc[ST_INTERRUPT_TWO])
        |=> interruptTwo ##1 status[ST_INTERRUPT_TWO])
        else $error("analog-in one edge not on interrupt two");

    mask_irq_a: assert property (status[ST_DEMOD] && mask[ST_DEMOD] |-> irq)
        else $error("unmasked status without interrupt");

    timer_out4_a: assert property (timerSel[TSEL_EIGHT_BIT]
        |=> portThreeOut[4] == $past(eightBitTimerOutput))
        else $error("eight-bit output not on output four");

endmodule : tcf_timer_common_control

`default_nettype wire

// *** tcf_pin_model.sv ***
/* Far-side model: receiver and analog pins facing the block.
   Assumes the bench moves pins through drive(), one edge at a time. */
`timescale 1ns/1ps
`default_nettype none
module tcf_pin_model (
    // Clock and comparator power
    input  wire logic ref_clk,
    input  wire logic comparatorPowerEn,
    // Pin levels toward the block
    output logic      analogInOnePin,
    output logic      analogInTwoPin,
    output logic      referenceTwoPin,
    output logic      portTwoBitZeroPin,
    // Comparator results
    output logic      comparatorOneResult,
    output logic      comparatorTwoResult
);
    logic [1:0] cmpLevel; // Analog comparison while powered
    // Pins change only just after a rising edge
    task automatic drive(input logic [3:0] pins, input logic [1:0] cmp);
        @(posedge ref_clk);
        {analogInOnePin, analogInTwoPin, referenceTwoPin, portTwoBitZeroPin} <= pins;
        cmpLevel <= cmp;
    endtask : drive
    initial begin
        {analogInOnePin, analogInTwoPin, referenceTwoPin, portTwoBitZeroPin} = 4'h0;
        cmpLevel = 2'h0;
    end
    // An unpowered comparator gives no result, so it reads low
    assign comparatorOneResult = comparatorPowerEn & cmpLevel[0];
    assign comparatorTwoResult = comparatorPowerEn & cmpLevel[1];
endmodule : tcf_pin_model
`default_nettype wire

// *** tcf_testbench.sv ***
/* Self-checking bench for the timer common-function control block.
   Assumes the pin model stands on the far side and hreadyout is hready. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
    import tcf_pkg::*;
    // Clock, reset and bus
    logic        ref_clk, rst, hsel, hwrite, hreadyout;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    wire         hready = hreadyout; // Single slave drives bus ready
    // Timers, pins and outputs
    logic        eightBitTimerOutput, sixteenBitTimerOutput, stopMode, exp;
    logic        analogInOnePin, analogInTwoPin, referenceTwoPin, portTwoBitZeroPin;
    logic        comparatorOneResult, comparatorTwoResult, comparatorPowerEn;
    logic        alternatingTimerMode, initialEightLevel, demodEdge, irq;
    logic [7:4]  portThreeData, portThreeOut;
    int          errors, checksDone, edgeCount, n;
    tcf_timer_common_control tcf_timer_common_control_i (.ref_clk, .rst, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp(),
        .eightBitTimerOutput, .sixteenBitTimerOutput, .demodMode(), .alternatingTimerMode,
        .initialEightLevel, .demodEdge, .analogInOnePin, .analogInTwoPin, .referenceTwoPin,
        .portTwoBitZeroPin, .comparatorOneResult, .comparatorTwoResult, .stopMode,
        .comparatorPowerEn, .portThreeData, .portThreeOut, .interruptZero(),
        .interruptOne(), .interruptTwo(), .irq);
    tcf_pin_model tcf_pin_model_i (.ref_clk, .comparatorPowerEn, .analogInOnePin,
        .analogInTwoPin, .referenceTwoPin, .portTwoBitZeroPin, .comparatorOneResult,
        .comparatorTwoResult);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Count demodulator edge pulses
    always @(posedge ref_clk) if (demodEdge === 1'b1) edgeCount++;
    // One whole-word transfer; an idle cycle always comes first
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
        #1;
    endtask : bus
    task automatic settle(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : settle
    // Reset contents and an unmapped read
    task automatic reset_vals;
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd[7:0], CTRL_RESET)
        bus(1'b0, 8'h3C, 32'h0);
        `CHK(rd, 32'h0)
    endtask : reset_vals
    // All codes on all input pairs, routing, submodes
    task automatic transmit;
        bus(1'b1, 8'h00, 32'h3);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 8'h04, 32'h40 | (c << 4));
            for (int ab = 0; ab < 4; ab++) begin
                eightBitTimerOutput <= ab[1];
                sixteenBitTimerOutput <= ab[0];
                settle(2);
                case (c)
                    0: exp = ab[1] & ab[0];
                    1: exp = ab[1] | ab[0];
                    2: exp = ~(ab[1] | ab[0]);
                    default: exp = ~(ab[1] & ab[0]);
                endcase
                `CHK(portThreeOut[6], exp)
                `CHK(portThreeOut[5:4], {ab[0], ab[1]})
            end
        end
        bus(1'b1, 8'h04, 32'h0);
        portThreeData <= 4'h4;
        settle(2);
        `CHK(portThreeOut[6], 1'b1)
        for (int s = 1; s < 4; s++) begin
            sixteenBitTimerOutput <= (s == 2);
            bus(1'b1, 8'h04, 32'(s << 2));
            settle(2);
            `CHK(alternatingTimerMode, (s == 1))
            if (s > 1) `CHK(portThreeOut[5], (s == 3))
        end
        bus(1'b1, 8'h04, 32'h2);
        `CHK(initialEightLevel, 1'b1)
    endtask : transmit
    // Rising flag, its clear, input choice and both filter lengths
    task automatic demod;
        bus(1'b1, 8'h14, 32'h8);
        bus(1'b1, 8'h04, 32'hD0);
        tcf_pin_model_i.drive(4'b0001, 2'h0);
        settle(3);
        `CHK(irq, 1'b1)
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd[1], 1'b1)
        bus(1'b1, 8'h04, 32'hD2);
        bus(1'b1, 8'h10, 32'h8);
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd[1], 1'b0)
        `CHK(irq, 1'b0)
        bus(1'b1, 8'h04, 32'h90);
        tcf_pin_model_i.drive(4'b0000, 2'h0);
        n = edgeCount;
        tcf_pin_model_i.drive(4'b0001, 2'h0);
        settle(3);
        `CHK(edgeCount, n)
        tcf_pin_model_i.drive(4'b1001, 2'h0);
        settle(3);
        `CHK(edgeCount, n + 1)
        for (int f = 1; f < 3; f++) begin
            bus(1'b1, 8'h04, 32'hA0 | (f << 2));
            tcf_pin_model_i.drive(4'b0001, 2'h0);
            settle(12);
            n = edgeCount;
            tcf_pin_model_i.drive(4'b1001, 2'h0);
            repeat (f * 4 - 2) @(posedge ref_clk);
            tcf_pin_model_i.drive(4'b0001, 2'h0);
            settle(12);
            `CHK(edgeCount, n)
            tcf_pin_model_i.drive(4'b1001, 2'h0);
            settle(12);
            `CHK(edgeCount, n + 1)
        end
    endtask : demod
    // Pin interrupts raised, masked and cleared
    task automatic pin_irq;
        bus(1'b1, 8'h0C, 32'h40);
        bus(1'b1, 8'h10, 32'hF);
        bus(1'b1, 8'h14, 32'h2);
        tcf_pin_model_i.drive(4'b0110, 2'h0);
        settle(3);
        `CHK(irq, 1'b1)
        tcf_pin_model_i.drive(4'b1010, 2'h0);
        settle(3);
        bus(1'b0, 8'h10, 32'h0);
        `CHK(rd[2:0], 3'h7)
        bus(1'b1, 8'h14, 32'h0);
        `CHK(irq, 1'b0)
        bus(1'b1, 8'h10, 32'h2);
        bus(1'b1, 8'h14, 32'h2);
        `CHK(irq, 1'b0)
    endtask : pin_irq
    // Comparator power follows the analog enable and stop mode
    task automatic analog_power;
        bus(1'b1, 8'h08, 32'h2);
        tcf_pin_model_i.drive(4'b0000, 2'h2);
        settle(2);
        `CHK(comparatorPowerEn, 1'b1)
        `CHK(portThreeOut[7], 1'b1)
        stopMode <= 1'b1;
        #1;
        `CHK(comparatorPowerEn, 1'b0)
    endtask : analog_power
    task automatic wrap_up;
        $display("checks %0d errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        {rst, hsel, hwrite, haddr, htrans, hsize, hwdata} = {3'h4, 8'h0, 2'h0, 3'h2, 32'h0};
        {eightBitTimerOutput, sixteenBitTimerOutput, stopMode, portThreeData} = 7'h0;
        {errors, checksDone, edgeCount} = 0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        reset_vals();
        transmit();
        demod();
        pin_irq();
        analog_power();
        wrap_up();
    end
    // Run takes a few hundred cycles
    initial begin
        #200us;
        errors++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
